// File: rtl/acs_pkg.sv
// Constants and carrier types of the automatic channel sequencer.
// Assumes a 16-bit reconfiguration port and a 12-bit converter.
// Operation
// - Averaging depth 16, 64 or 256 samples
// - Averaging enable per channel, selection bit map
// - End pulse only after full averaging count
// - Unaveraged channel status written every pass
// - Averaged channel status written when count done
// - Calibration updates first pass, then every 16
// - Input mode bit one is bipolar, zero unipolar
// - Internal sensors always converted unipolar
// - External channel settling four clock cycles
// - Long settle bit gives ten clock cycles
// - Mode zero runs fixed sensor monitoring sequence
// - Default mode ignores other control settings
// - Default mode at power-up and configuration
// - Default mode gates alarms except over-temperature, keeps calibration on
// - Default order calibration, temp, supplies
// - Single pass repeats selected channels until averaging count done, halts
// - Each mode write starts a new pass
// - After pass convert single selected channel
// - Continuous mode restarts pass while selected
// - Mode write resets logic and averaging
// - Fixed order from low to high bit
// - Selection bit one includes the channel
package acs_pkg;
    localparam logic [6:0]  CFG0_ADDR     = 7'h40;
    localparam logic [6:0]  CFG1_ADDR     = 7'h41;
    localparam logic [6:0]  STATE_ADDR    = 7'h43;
    localparam logic [6:0]  SEL0_ADDR     = 7'h48;
    localparam logic [6:0]  SEL1_ADDR     = 7'h49;
    localparam logic [6:0]  AVERAGE_DEPTH_LO_ADDR     = 7'h4a;
    localparam logic [6:0]  AVERAGE_DEPTH_HI_ADDR     = 7'h4b;
    localparam logic [6:0]  BIP0_ADDR     = 7'h4c;
    localparam logic [6:0]  BIP1_ADDR     = 7'h4d;
    localparam logic [6:0]  SET0_ADDR     = 7'h4e;
    localparam logic [6:0]  SET1_ADDR     = 7'h4f;
    localparam logic [6:0]  STAT_CAL_ADDR = 7'h08;
    localparam int          CH_LSB        = 0;
    localparam int          AVG_LSB       = 12;
    localparam int          CALIB_AVERAGE_OFF_BIT      = 15;
    localparam int          SEQ_LSB       = 12;
    localparam logic [15:0] REG_RST       = 16'h0000;
    localparam logic [3:0]  MODE_DEFAULT  = 4'h0;
    localparam logic [3:0]  SETTLE_SHORT  = 4'h4;
    localparam logic [3:0]  SETTLE_LONG   = 4'ha;
    localparam logic [3:0]  CAL_LAST      = 4'hf;
    localparam logic [3:0]  SH16          = 4'h4;
    localparam logic [3:0]  SH64          = 4'h6;
    localparam logic [3:0]  SH256         = 4'h8;
    localparam logic [4:0]  IDX_CAL       = 5'h00;
    localparam logic [4:0]  IDX_VPVN      = 5'h0b;
    localparam logic [4:0]  IDX_LAST      = 5'h1f;
    localparam logic [31:0] DFLT_SEL      = 32'h0000_4701;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SCAN   = 3'b001,
        ST_SETTLE = 3'b010,
        ST_CONV   = 3'b011,
        ST_STORE  = 3'b100
    } acs_state_t;

    typedef struct packed {
        logic [5:0] chan;
        logic       bipolar;
    } acs_conv_req_t;

    typedef struct packed {
        logic [6:0]  addr;
        logic [15:0] data;
    } acs_status_wr_t;
endpackage : acs_pkg

// File: rtl/acs_sequencer.sv
// Automatic channel sequencer with its reconfiguration port registers.
// Assumes a converter that answers each start with one done pulse.
`timescale 1ns/1ps
module acs_sequencer
    import acs_pkg::*;
#(
    parameter logic [3:0] SINGLE_CODE = 4'h1,
    parameter logic [3:0] CONT_CODE   = 4'h2
) (
    // Clock and reset
    input  logic           clk_i,
    input  logic           rst_n_i,
    // Reconfiguration port
    input  logic           den_i,
    input  logic           dwe_i,
    input  logic [6:0]     daddr_i,
    input  logic [15:0]    di_i,
    output logic [15:0]    do_o,
    output logic           drdy_o,
    // Surrounding device state
    input  logic           config_busy_i,
    // Converter
    output logic           conv_start_o,
    output acs_conv_req_t  conv_req_o,
    input  logic           conv_done_i,
    input  logic [11:0]    conv_data_i,
    // Status register writes
    output logic           status_we_o,
    output acs_status_wr_t status_wr_o,
    output logic           sequence_done_pulse_o,
    output logic           calib_enable_o,
    // Alarms
    input  logic [7:0]     alarm_raw_i,
    input  logic           over_temperature_alarm_i,
    output logic [7:0]     alarm_outputs_o,
    output logic           over_temperature_alarm_o
);

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    logic [15:0] cfg0, cfg1, sel0, sel1, average_depth_lo, average_depth_hi;
    logic [15:0] bip0, bip1, set0, set1, rd_mux;
    acs_state_t  st, next_st;
    logic [4:0]  idx;
    logic [7:0]  pass_cnt;
    logic [3:0]  scnt, cal_cnt;
    logic        cal_first, single_done;
    logic        dflt, sc;
    logic [19:0] acc [32];

    wire wr      = den_i & dwe_i;
    wire mode_wr = wr & (daddr_i == CFG1_ADDR);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg0 <= REG_RST;
            cfg1 <= REG_RST;
            sel0 <= REG_RST;
            sel1 <= REG_RST;
            average_depth_lo <= REG_RST;
            average_depth_hi <= REG_RST;
            bip0 <= REG_RST;
            bip1 <= REG_RST;
            set0 <= REG_RST;
            set1 <= REG_RST;
        end else if (wr) begin
            case (daddr_i)
                CFG0_ADDR: cfg0 <= di_i;
                CFG1_ADDR: cfg1 <= di_i;
                SEL0_ADDR: sel0 <= di_i;
                SEL1_ADDR: sel1 <= di_i;
                AVERAGE_DEPTH_LO_ADDR: average_depth_lo <= di_i;
                AVERAGE_DEPTH_HI_ADDR: average_depth_hi <= di_i;
                BIP0_ADDR: bip0 <= di_i;
                BIP1_ADDR: bip1 <= di_i;
                SET0_ADDR: set0 <= di_i;
                SET1_ADDR: set1 <= di_i;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (daddr_i)
            CFG0_ADDR:  rd_mux = cfg0;
            CFG1_ADDR:  rd_mux = cfg1;
            SEL0_ADDR:  rd_mux = sel0;
            SEL1_ADDR:  rd_mux = sel1;
            AVERAGE_DEPTH_LO_ADDR:  rd_mux = average_depth_lo;
            AVERAGE_DEPTH_HI_ADDR:  rd_mux = average_depth_hi;
            BIP0_ADDR:  rd_mux = bip0;
            BIP1_ADDR:  rd_mux = bip1;
            SET0_ADDR:  rd_mux = set0;
            SET1_ADDR:  rd_mux = set1;
            STATE_ADDR: rd_mux = {5'h00, st, single_done, dflt, sc, idx};
            default:    rd_mux = REG_RST;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            do_o   <= REG_RST;
            drdy_o <= 1'b0;
        end else begin
            drdy_o <= den_i;
            if (den_i & ~dwe_i)
                do_o <= rd_mux;
        end
    end

    // ----------------------------------------
    // Effective sequence settings
    // ----------------------------------------
    wire [3:0] mode = cfg1[SEQ_LSB +: 4];
    assign dflt = config_busy_i | (mode == MODE_DEFAULT);
    // Default mode overrides every user setting
    wire [31:0] sel_v = dflt ? DFLT_SEL : {sel1, sel0};
    wire [31:0] avg_v = dflt ? DFLT_SEL : {average_depth_hi, average_depth_lo};
    wire [31:0] bip_v = dflt ? 32'h0000_0000 : {bip1, bip0};
    wire [31:0] lng_v = dflt ? 32'h0000_0000 : {set1, set0};
    wire [1:0]  depth = cfg0[AVG_LSB +: 2];
    wire [3:0]  sh = (dflt | depth < 2'h2) ? SH16 :
                     (depth == 2'h2) ? SH64 : SH256;
    // Last pass index: averaging depth minus one
    wire [7:0]  pmask = 8'hff >> (4'h8 - sh);
    wire cal_avg  = dflt | ~cfg0[CALIB_AVERAGE_OFF_BIT];
    wire any_avg  = |(sel_v & avg_v & ~32'h0000_0001);
    wire avg_last = (pass_cnt == pmask);
    wire eos_now  = ~any_avg | avg_last;
    wire seq_act  = dflt | (mode == CONT_CODE)
                  | ((mode == SINGLE_CODE) & ~single_done);
    assign sc     = ~seq_act;
    wire is_cal   = seq_act & (idx == IDX_CAL);
    wire ext      = idx[4] | (idx == IDX_VPVN);
    // Bit index to converter channel; single channel from field
    wire [5:0] chn = sc ? cfg0[CH_LSB +: 6] :
                     {1'b0, idx[4], idx[3] ^ ~idx[4], idx[2:0]};
    wire bip_now  = ~sc & ext & bip_v[idx];
    wire lng_now  = ~sc & ext & lng_v[idx];
    wire last_bit = (idx == IDX_LAST);
    wire end_pass = seq_act & last_bit &
                    ((st == ST_SCAN & ~sel_v[idx]) | st == ST_STORE);
    // Converter result accepted only while waiting
    wire take     = (st == ST_CONV) & conv_done_i;

    // ----------------------------------------
    // Averaging and status update decision
    // ----------------------------------------
    // Calibration keeps its own sixteen-sample count
    wire a_on   = is_cal ? (cal_avg & ~cal_first)
                         : (seq_act & avg_v[idx]);
    wire a_last = is_cal ? (cal_cnt == CAL_LAST) : avg_last;
    wire [3:0]  a_sh   = is_cal ? SH16 : sh;
    wire [19:0] sum    = acc[idx] + {8'h00, conv_data_i};
    wire [19:0] sh_sum = sum >> a_sh;
    wire do_wr  = ~a_on | a_last;
    wire [11:0] res = a_on ? sh_sum[11:0] : conv_data_i;

    // Start fires in the last settle cycle
    assign conv_start_o = (st == ST_SETTLE) & (scnt == 4'h0);
    assign calib_enable_o = sel_v[IDX_CAL];
    assign alarm_outputs_o = dflt ? 8'h00 : alarm_raw_i;
    assign over_temperature_alarm_o = over_temperature_alarm_i;

    // ----------------------------------------
    // Sequencer state machine
    // ----------------------------------------
    always_comb begin
        next_st = st;
        case (st)
            ST_IDLE:   next_st = ST_SCAN;
            ST_SCAN:   if (sc | sel_v[idx]) next_st = ST_SETTLE;
            ST_SETTLE: if (scnt == 4'h0) next_st = ST_CONV;
            ST_CONV:   if (conv_done_i) next_st = ST_STORE;
            ST_STORE:  next_st = ST_SCAN;
            default:   next_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st          <= ST_IDLE;
            idx         <= IDX_CAL;
            pass_cnt    <= 8'h00;
            scnt        <= 4'h0;
            cal_cnt     <= 4'h0;
            cal_first   <= 1'b1;
            single_done <= 1'b0;
            conv_req_o  <= '0;
            sequence_done_pulse_o <= 1'b0;
        end else if (mode_wr) begin
            st          <= ST_IDLE;
            idx         <= IDX_CAL;
            pass_cnt    <= 8'h00;
            cal_cnt     <= 4'h0;
            cal_first   <= 1'b1;
            single_done <= 1'b0;
            sequence_done_pulse_o <= 1'b0;
        end else begin
            st <= next_st;
            sequence_done_pulse_o <= end_pass & eos_now;
            if (st == ST_SCAN && next_st == ST_SETTLE) begin
                conv_req_o <= '{chan: chn, bipolar: bip_now};
                scnt <= lng_now ? SETTLE_LONG - 4'h1
                                : SETTLE_SHORT - 4'h1;
            end else if (st == ST_SETTLE) begin
                scnt <= scnt - 4'h1;
            end
            if (end_pass) begin
                idx       <= IDX_CAL;
                cal_first <= 1'b0;
                pass_cnt  <= eos_now ? 8'h00 : pass_cnt + 8'h01;
                if (eos_now & ~dflt & (mode == SINGLE_CODE))
                    single_done <= 1'b1;
            end else if (~sc & ((st == ST_SCAN & ~sel_v[idx])
                                | st == ST_STORE)) begin
                idx <= idx + 5'h01;
            end
            if (take & is_cal & a_on)
                cal_cnt <= cal_cnt + 4'h1;
        end
    end

    // Status write of the converted or averaged result
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_we_o <= 1'b0;
            status_wr_o <= '0;
        end else begin
            // Restart in the same cycle drops the write
            status_we_o <= take & do_wr & ~mode_wr;
            if (take)
                status_wr_o <= '{addr: {1'b0, chn}, data: {res, 4'h0}};
        end
    end

    // Per-bit averaging sums, cleared on restart
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 32; i++)
                acc[i] <= 20'h0_0000;
        end else if (mode_wr) begin
            for (int i = 0; i < 32; i++)
                acc[i] <= 20'h0_0000;
        end else if (take & a_on) begin
            acc[idx] <= a_last ? 20'h0_0000 : sum;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_load_long;
        st == ST_SCAN && next_st == ST_SETTLE && lng_now;
    endsequence
    sequence s_load_short;
        st == ST_SCAN && next_st == ST_SETTLE && !lng_now;
    endsequence

    a_settle_long: assert property (disable iff (!rst_n_i || mode_wr)
        s_load_long |-> ##10 conv_start_o)
        else $error("long settle not ten cycles");
    a_settle_short: assert property (disable iff (!rst_n_i || mode_wr)
        s_load_short |=> (!conv_start_o [*3]) ##1 conv_start_o)
        else $error("short settle not four cycles");
    a_int_unipolar: assert property (
        conv_start_o && conv_req_o.chan < 6'h10
        && conv_req_o.chan != 6'h03 |-> !conv_req_o.bipolar)
        else $error("internal channel converted bipolar");
    a_dflt_alarm: assert property (
        dflt |-> alarm_outputs_o == 8'h00 && calib_enable_o)
        else $error("default mode alarm or calibration wrong");
    a_restart_clear: assert property (
        mode_wr |=> st == ST_IDLE && pass_cnt == 8'h00
                    && !sequence_done_pulse_o && !status_we_o)
        else $error("mode write did not restart");
    a_eos_held: assert property (
        end_pass && any_avg && !avg_last |=> !sequence_done_pulse_o)
        else $error("end pulse before averaging done");
    a_eos_plain: assert property (
        end_pass && !any_avg && !mode_wr |=> sequence_done_pulse_o)
        else $error("end pulse missing");
    a_noavg_write: assert property (
        take && seq_act && !is_cal && !avg_v[idx] && !mode_wr
        |=> status_we_o && status_wr_o.data[15:4] == $past(conv_data_i))
        else $error("plain channel status not written");
    a_avg_hold: assert property (
        take && seq_act && !is_cal && avg_v[idx] && !avg_last
        |=> !status_we_o)
        else $error("averaged status written early");
    a_cal_first: assert property (
        take && is_cal && cal_first && !mode_wr
        |=> status_we_o && status_wr_o.addr == STAT_CAL_ADDR)
        else $error("first calibration not stored");
    a_single_halt: assert property (
        end_pass && eos_now && !dflt && mode == SINGLE_CODE
        && !mode_wr |=> sc)
        else $error("single pass did not halt");

endmodule : acs_sequencer

// File: verif/acs_host_model.sv
// Host logic model driving the reconfiguration port.
// Assumes one access in flight, launched at the falling clock edge.
`timescale 1ns/1ps
module acs_host_model (
    // Clock
    input  logic        clk_i,
    // Reconfiguration port
    output logic        den_o,
    output logic        dwe_o,
    output logic [6:0]  daddr_o,
    output logic [15:0] di_o,
    input  logic [15:0] do_i,
    input  logic        drdy_i
);
    logic [15:0] rd_data = 16'h0000;
    int          tmo     = 0;

    initial begin
        den_o   = 1'b0;
        dwe_o   = 1'b0;
        daddr_o = 7'h00;
        di_o    = 16'h0000;
    end

    // One-cycle enable, then a bounded wait for the ready pulse
    task automatic access(input logic we, input logic [6:0] addr,
                          input logic [15:0] data);
        int n;
        @(negedge clk_i);
        den_o   <= 1'b1;
        dwe_o   <= we;
        daddr_o <= addr;
        di_o    <= data;
        @(negedge clk_i);
        den_o   <= 1'b0;
        dwe_o   <= 1'b0;
        daddr_o <= ~addr;
        di_o    <= ~data;
        n = 0;
        while (drdy_i !== 1'b1 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        if (drdy_i === 1'b1) rd_data = do_i;
        else tmo++;
    endtask : access
endmodule : acs_host_model

// File: verif/acs_sequencer_tb.sv
// Self-checking bench of the automatic channel sequencer.
// Assumes the host model on the port and a converter model here.
`timescale 1ns/1ps
module acs_sequencer_tb
    import acs_pkg::*;
;
    localparam logic [3:0] SGL = 4'h1;
    localparam logic [3:0] CNT = 4'h2;
    localparam logic [6:0] DCH [5] = '{7'h10, 7'h00, 7'h02, 7'h04, 7'h0c};
    localparam logic [6:0] SPX [4] = '{7'h00, 7'h07, 7'h22, 7'h0a};
    localparam logic [7:0] SPG [4] = '{8'h00, 8'h03, 8'h09, 8'h03};
    logic           clk_i, rst_n_i, den, dwe, drdy, cal_en, ot_o;
    logic           conv_start, st_we, seq_done;
    logic           busy = 1'b0;
    logic           ot = 1'b0;
    logic           conv_done = 1'b0;
    logic [11:0]    conv_data = 12'h000;
    logic [11:0]    cv;
    logic [7:0]     alm_raw = 8'h00;
    logic [7:0]     alm_o;
    logic [6:0]     daddr;
    logic [15:0]    di, dout, v;
    acs_conv_req_t  req, prev_req;
    acs_status_wr_t st_wr;
    logic [127:0]   raw_chk = '0;
    logic [14:0]    st_q[$];
    int             num_errors, checked, nstart, dcnt, gap, cd_cnt, seed;
    int             asum, ash;
    int             wcnt[128];

    acs_sequencer #(.SINGLE_CODE(SGL), .CONT_CODE(CNT)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .den_i(den), .dwe_i(dwe),
        .daddr_i(daddr), .di_i(di), .do_o(dout), .drdy_o(drdy),
        .config_busy_i(busy), .conv_start_o(conv_start),
        .conv_req_o(req), .conv_done_i(conv_done),
        .conv_data_i(conv_data), .status_we_o(st_we),
        .status_wr_o(st_wr), .sequence_done_pulse_o(seq_done),
        .calib_enable_o(cal_en), .alarm_raw_i(alm_raw),
        .over_temperature_alarm_i(ot), .alarm_outputs_o(alm_o),
        .over_temperature_alarm_o(ot_o));

    acs_host_model host (
        .clk_i(clk_i), .den_o(den), .dwe_o(dwe), .daddr_o(daddr),
        .di_o(di), .do_i(dout), .drdy_i(drdy));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : check

    // Averaging shift for a depth code
    function automatic int avg_shift(input int code);
        return (code < 2) ? 4 : (code == 2) ? 6 : 8;
    endfunction : avg_shift

    task automatic print_verdict();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic wait_for(ref int cnt, input int n);
        int k;
        k = 0;
        while (cnt < n && k < 40000) begin
            @(posedge clk_i);
            k++;
        end
        if (cnt < n) begin
            num_errors++;
            print_verdict();
        end
    endtask : wait_for

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        host.access(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [6:0] a, input logic [15:0] exp);
        host.access(1'b0, a, 16'h0000);
        check(host.rd_data, exp);
    endtask : rd_chk

    task automatic setup(input logic [15:0] s0, s1, a1, b0, t1, c0,
                         input logic [3:0] mode, input logic [127:0] rc);
        wr(CFG1_ADDR, 16'h0000);
        wr(SEL0_ADDR, s0);
        wr(SEL1_ADDR, s1);
        wr(AVERAGE_DEPTH_LO_ADDR, 16'h0000);
        wr(AVERAGE_DEPTH_HI_ADDR, a1);
        wr(BIP0_ADDR, b0);
        wr(BIP1_ADDR, 16'h0000);
        wr(SET0_ADDR, 16'h0000);
        wr(SET1_ADDR, t1);
        wr(CFG0_ADDR, c0);
        raw_chk = rc;
        wr(CFG1_ADDR, {mode, 12'h000});
        @(posedge clk_i);
        wcnt = '{default: 0};
        dcnt = 0;
        nstart = 0;
        st_q.delete();
        cd_cnt = 0;
        asum = 0;
    endtask : setup

    // Converter answers each start after one to four cycles
    always @(negedge clk_i) begin
        conv_done <= 1'b0;
        gap = (req !== prev_req) ? 0 : gap + 1;
        prev_req = req;
        if (conv_start === 1'b1) begin
            cd_cnt = 1 + ($random(seed) & 3);
            st_q.push_back({gap[7:0], req});
            nstart++;
        end else if (cd_cnt > 0) begin
            cd_cnt--;
            if (cd_cnt == 0) begin
                cv = 12'($random(seed));
                conv_done <= 1'b1;
                conv_data <= cv;
                if (req.chan == 6'h11) asum += cv;
            end
        end
        if (st_we === 1'b1) begin
            wcnt[st_wr.addr]++;
            if (raw_chk[st_wr.addr]) check(st_wr.data, {conv_data, 4'h0});
            else if (st_wr.addr == 7'h11) begin
                check(st_wr.data, {12'(asum >> ash), 4'h0});
                asum = 0;
            end
        end
        if (seq_done === 1'b1) dcnt++;
    end

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        seed = 42748;
        rst_n_i = 1'b0;
        repeat (6) @(negedge clk_i);
        rst_n_i = 1'b1;
        alm_raw = 8'($random(seed));
        ot = 1'b1;
        #1;
        check(alm_o, 8'h00);
        check(ot_o, 1'b1);
        check(cal_en, 1'b1);
        for (int i = 0; i < 6; i++) begin
            rd_chk(AVERAGE_DEPTH_LO_ADDR + 7'(i), REG_RST);
            v = 16'($random(seed));
            wr(AVERAGE_DEPTH_LO_ADDR + 7'(i), v);
            rd_chk(AVERAGE_DEPTH_LO_ADDR + 7'(i), v);
        end
        rd_chk(7'h7f, 16'h0000);
        wait_for(nstart, 5);
        for (int i = 0; i < 5; i++) check(st_q[i][6:0], DCH[i]);
        wait_for(dcnt, 1);
        for (int i = 1; i < 5; i++) check(wcnt[DCH[i] >> 1], 1);
        check(wcnt[8], 1);
        wait_for(dcnt, 2);
        check(wcnt[8], 2);
        setup(16'h0900, 16'h0002, 16'h0000, 16'h0900, 16'h0002,
              16'h0005, SGL, 128'h0002_0029);
        wait_for(dcnt, 1);
        wait_for(nstart, 4);
        for (int i = 0; i < 4; i++) begin
            check(st_q[i][6:0], SPX[i]);
            if (i > 0) check(st_q[i][14:7], SPG[i]);
        end
        check(wcnt[17], 1);
        wr(CFG1_ADDR, {SGL, 12'h000});
        wait_for(dcnt, 2);
        check(wcnt[17], 2);
        @(negedge clk_i);
        alm_raw = 8'($random(seed));
        #1;
        check(alm_o, alm_raw);
        busy = 1'b1;
        repeat (2) @(negedge clk_i);
        check(alm_o, 8'h00);
        check(cal_en, 1'b1);
        busy = 1'b0;
        for (int d = 0; d < 4; d++) begin
            setup(16'h0100, 16'h0002, 16'h0002, 16'h0000, 16'h0000,
                  16'(d << 12), CNT, 128'h0001);
            ash = avg_shift(d);
            wait_for(dcnt, 1);
            check(wcnt[0], 1 << ash);
            check(wcnt[17], 1);
            wait_for(dcnt, 2);
            check(wcnt[17], 2);
        end
        check(host.tmo, 0);
        print_verdict();
    end
endmodule : acs_sequencer_tb
